// ---- src/asc_pkg.sv ----
package asc_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h93;
  localparam logic [7:0] OFS_SETUP = 8'h8F;
  localparam logic [7:0] OFS_DIV = 8'h94;
  localparam logic [7:0] OFS_PIN_LO = 8'h95;
  localparam logic [7:0] OFS_RES_LO = 8'h96;
  localparam logic [7:0] OFS_RES_HI = 8'h97;
  localparam logic [7:0] OFS_PIN_HI = 8'hC2;
  // control register field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_DONE_BIT = 6;
  localparam int CTRL_CMP_BIT = 5;
  localparam int CTRL_REF_BIT = 4;
  localparam int CTRL_START_BIT = 0;
  // converter_setup field positions
  localparam int SETUP_IREF_BIT = 7;
  localparam int SETUP_ALIGN_BIT = 6;
  localparam int SETUP_PUMP_BIT = 5;
  localparam int SETUP_RSVD_BIT = 4;
  localparam int SRC_W = 4;
  localparam int PIN_HI_BIT = 0;
  // input source codes
  localparam logic [3:0] SRC_IREF_CODE = 4'h9;
  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_SRC = 4'h0;
  localparam logic [9:0] RST_RESULT = 10'h000;
  // converter clock periods per conversion
  localparam int CONV_TICKS = 26;
endpackage

// ---- src/asc_clk_if.sv ----
`timescale 1ns/1ps
interface asc_clk_if #(parameter int DIV_W = 8);
  logic [DIV_W-1:0] div_value;
  logic run;
  logic tick;
  logic level;
  modport ctrl (output div_value, output run, input tick, input level);
  modport gen (input div_value, input run, output tick, output level);
endinterface

// ---- src/asc_clk_div.sv ----
`timescale 1ns/1ps
module asc_clk_div #(
  parameter int DIV_W = 8
) (
  input wire logic clk,    // system clock
  input wire logic arst_n, // async reset, active low
  asc_clk_if.gen cif       // divider value in, converter clock out
);
  if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
    $error("asc_clk_div: DIV_W out of range");
  end

  localparam logic [DIV_W:0] FULL = {1'b1, {DIV_W{1'b0}}};
  localparam logic [DIV_W:0] ONE = {{DIV_W{1'b0}}, 1'b1};

  logic [DIV_W:0] cnt_reg;
  logic [DIV_W:0] cnt_next;
  logic level_reg;
  logic level_next;
  wire [DIV_W:0] half = FULL - {1'b0, cif.div_value};
  wire wrap = cnt_reg >= (half - ONE);

  // half period of (FULL - value) system clocks, so period is 2*(FULL - value)
  assign cnt_next = (!cif.run || wrap) ? '0 : cnt_reg + ONE;
  assign level_next = !cif.run ? 1'b0 : (wrap ? ~level_reg : level_reg);
  assign cif.tick = cif.run && wrap && !level_reg;
  assign cif.level = level_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      level_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      level_reg <= level_next;
    end
  end

  // helper: cycles between ticks while the divider value holds still
  logic [DIV_W+1:0] gap_reg;
  logic [DIV_W-1:0] div_q_reg;
  logic steady_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg <= '0;
      div_q_reg <= '0;
      steady_reg <= 1'b0;
    end else begin
      div_q_reg <= cif.div_value;
      gap_reg <= cif.tick ? '0 : gap_reg + {{(DIV_W+1){1'b0}}, 1'b1};
      if (!cif.run || cif.div_value != div_q_reg) begin
        steady_reg <= 1'b0;
      end else if (cif.tick) begin
        steady_reg <= 1'b1;
      end
    end
  end

  chk_div_period: assert property (@(posedge clk) disable iff (!arst_n)
    (cif.tick && steady_reg && cif.div_value == div_q_reg) |-> (gap_reg + 1) == {half, 1'b0})
    else $error("converter clock period differs from divider setting");
endmodule

// ---- src/asc_result_fmt.sv ----
`timescale 1ns/1ps
module asc_result_fmt (
  input wire logic [9:0] result,     // latched conversion result
  input wire logic align_right,      // 1: right aligned
  output logic [7:0] high_byte,      // formatted high result byte
  output logic [7:0] low_byte        // formatted low result byte
);
  assign high_byte = align_right ? {6'h00, result[9:8]} : result[9:2];
  assign low_byte = align_right ? result[7:0] : {result[1:0], 6'h00};
endmodule

// ---- src/adc_setup_control.sv ----
// What this block does
// - external reference select routes P3.1 to converter
// - setup bit 7 switches 1.00V reference
// - align 0: high byte bits 9..2
// - align 1: high byte bits 9..8 low
// - alignment writes ignored while converting
// - setup bit 5 switches charge pump
// - source codes 0-8 inputs, 9 reference
// - converter clock is sysclk/2/(256-divider)
// - conversion lasts 26 converter clock periods
// - pin config low bits select analog pins
// - pin config high bit 0 selects P4.5
// - start flag starts, clears on completion
// - completion sets done flag, software clears
// - enable bit switches converter on/off
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module adc_setup_control #(
  parameter int CONV_TICKS = asc_pkg::CONV_TICKS
) (
  input wire logic REF_CLK,               // 100 MHz system clock
  input wire logic ARST_N,                // async reset, active low
  input wire logic [7:0] REG_ADDR,        // register byte address
  input wire logic [7:0] REG_WDATA,       // write data
  input wire logic REG_WR,                // write strobe
  input wire logic REG_RD,                // read strobe
  output logic [7:0] REG_RDATA,           // read data, cycle after strobe
  input wire logic [9:0] CORE_RESULT,     // result from converter core
  output logic CONV_CLK,                  // derived converter clock
  output logic CONV_ACTIVE,               // conversion in progress
  output logic CONVERTER_EN,              // converter powered
  output logic COMPARE_EN,                // compare enable to core
  output logic VREF_PIN_SEL,              // P3.1 used as reference input
  output logic INT_REF_EN,                // internal 1.00V reference on
  output logic CHARGE_PUMP_EN,            // charge pump on
  output logic [3:0] INPUT_SOURCE,        // converter input select
  output logic SRC_VALID,                 // select code is a legal one
  output logic INT_REF_SELECTED,          // internal reference is the input
  output logic [8:0] PIN_ANALOG_EN        // per-pin analog mode
);
  if (CONV_TICKS < 2 || CONV_TICKS > 31) begin : g_bad_ticks
    $error("adc_setup_control: CONV_TICKS out of range");
  end

  localparam logic [4:0] LAST_TICK = 5'(CONV_TICKS - 1);

  asc_clk_if #(.DIV_W(8)) clk_if ();

  // address decode
  wire wr_ctrl = REG_WR && REG_ADDR == asc_pkg::OFS_CTRL;
  wire wr_setup = REG_WR && REG_ADDR == asc_pkg::OFS_SETUP;
  wire wr_div = REG_WR && REG_ADDR == asc_pkg::OFS_DIV;
  wire wr_pin_lo = REG_WR && REG_ADDR == asc_pkg::OFS_PIN_LO;
  wire wr_pin_hi = REG_WR && REG_ADDR == asc_pkg::OFS_PIN_HI;
  wire rd_setup = REG_RD && REG_ADDR == asc_pkg::OFS_SETUP;
  wire rd_pin_hi = REG_RD && REG_ADDR == asc_pkg::OFS_PIN_HI;
  wire rd_res_lo = REG_RD && REG_ADDR == asc_pkg::OFS_RES_LO;
  wire rd_res_hi = REG_RD && REG_ADDR == asc_pkg::OFS_RES_HI;

  logic en_reg;
  logic done_reg;
  logic cmp_reg;
  logic ref_reg;
  logic busy_reg;
  logic iref_reg;
  logic align_reg;
  logic pump_reg;
  logic [3:0] src_reg;
  logic src_valid_reg;
  logic src_iref_reg;
  logic [7:0] div_reg;
  logic [7:0] pin_lo_reg;
  logic pin_hi_reg;
  logic [9:0] result_reg;
  logic [4:0] tick_cnt_reg;
  logic [7:0] rdata_reg;

  // conversion sequencing
  wire conv_done = busy_reg && clk_if.tick && tick_cnt_reg == LAST_TICK;
  // start needs the enable bit of the same write; disabling aborts
  wire start_wr = wr_ctrl && REG_WDATA[asc_pkg::CTRL_START_BIT]
                  && REG_WDATA[asc_pkg::CTRL_EN_BIT];
  wire busy_next = conv_done ? 1'b0 : (wr_ctrl ? start_wr : busy_reg && en_reg);
  wire [4:0] tick_cnt_next = !busy_next ? 5'h00 :
                             ((busy_reg && clk_if.tick) ? tick_cnt_reg + 5'h01 : tick_cnt_reg);
  // set wins over a clearing write in the same cycle
  wire done_next = conv_done ||
                   (wr_ctrl ? (done_reg && REG_WDATA[asc_pkg::CTRL_DONE_BIT]) : done_reg);
  // alignment is frozen while a conversion owns the result path
  wire align_next = (wr_setup && !busy_reg) ? REG_WDATA[asc_pkg::SETUP_ALIGN_BIT]
                                            : align_reg;
  wire [3:0] src_next = wr_setup ? REG_WDATA[asc_pkg::SRC_W-1:0] : src_reg;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      en_reg <= 1'b0;
      cmp_reg <= 1'b0;
      ref_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      tick_cnt_reg <= 5'h00;
    end else begin
      if (wr_ctrl) begin
        en_reg <= REG_WDATA[asc_pkg::CTRL_EN_BIT];
        cmp_reg <= REG_WDATA[asc_pkg::CTRL_CMP_BIT];
        ref_reg <= REG_WDATA[asc_pkg::CTRL_REF_BIT];
      end
      busy_reg <= busy_next;
      done_reg <= done_next;
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      iref_reg <= 1'b0;
      pump_reg <= 1'b0;
      align_reg <= 1'b0;
      src_reg <= asc_pkg::RST_SRC;
      src_valid_reg <= 1'b1;
      src_iref_reg <= 1'b0;
    end else begin
      if (wr_setup) begin
        iref_reg <= REG_WDATA[asc_pkg::SETUP_IREF_BIT];
        pump_reg <= REG_WDATA[asc_pkg::SETUP_PUMP_BIT];
      end
      align_reg <= align_next;
      src_reg <= src_next;
      src_valid_reg <= src_next <= asc_pkg::SRC_IREF_CODE;
      src_iref_reg <= src_next == asc_pkg::SRC_IREF_CODE;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_reg <= asc_pkg::RST_BYTE;
      pin_lo_reg <= asc_pkg::RST_BYTE;
      pin_hi_reg <= 1'b0;
      result_reg <= asc_pkg::RST_RESULT;
    end else begin
      if (wr_div) begin
        div_reg <= REG_WDATA;
      end
      if (wr_pin_lo) begin
        pin_lo_reg <= REG_WDATA;
      end
      if (wr_pin_hi) begin
        pin_hi_reg <= REG_WDATA[asc_pkg::PIN_HI_BIT];
      end
      if (conv_done) begin
        result_reg <= CORE_RESULT;
      end
    end
  end

  assign clk_if.div_value = div_reg;
  assign clk_if.run = en_reg;

  asc_clk_div #(.DIV_W(8)) u_div (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .cif(clk_if.gen)
  );

  wire [7:0] res_hi;
  wire [7:0] res_lo;
  asc_result_fmt u_fmt (
    .result(result_reg),
    .align_right(align_reg),
    .high_byte(res_hi),
    .low_byte(res_lo)
  );

  // read selection; unused bits are constant zero
  wire [7:0] ctrl_rd = {en_reg, done_reg, cmp_reg, ref_reg, 3'h0, busy_reg};
  wire [7:0] setup_rd = {iref_reg, align_reg, pump_reg, 1'b0, src_reg};
  wire [7:0] pin_hi_rd = {7'h00, pin_hi_reg};
  wire [7:0] rd_mux =
    (REG_ADDR == asc_pkg::OFS_CTRL) ? ctrl_rd :
    (REG_ADDR == asc_pkg::OFS_SETUP) ? setup_rd :
    (REG_ADDR == asc_pkg::OFS_DIV) ? div_reg :
    (REG_ADDR == asc_pkg::OFS_PIN_LO) ? pin_lo_reg :
    (REG_ADDR == asc_pkg::OFS_RES_LO) ? res_lo :
    (REG_ADDR == asc_pkg::OFS_RES_HI) ? res_hi :
    (REG_ADDR == asc_pkg::OFS_PIN_HI) ? pin_hi_rd : 8'h00;
  wire [7:0] rdata_next = REG_RD ? rd_mux : 8'h00;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign CONV_CLK = clk_if.level;
  assign CONV_ACTIVE = busy_reg;
  assign CONVERTER_EN = en_reg;
  assign COMPARE_EN = cmp_reg;
  assign VREF_PIN_SEL = ref_reg;
  assign INT_REF_EN = iref_reg;
  assign CHARGE_PUMP_EN = pump_reg;
  assign INPUT_SOURCE = src_reg;
  assign SRC_VALID = src_valid_reg;
  assign INT_REF_SELECTED = src_iref_reg;
  assign PIN_ANALOG_EN = {pin_hi_reg, pin_lo_reg};

  // helper: converter clock ticks seen since the conversion began
  logic [5:0] ticks_seen_reg;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ticks_seen_reg <= 6'h00;
    end else if (!busy_reg) begin
      ticks_seen_reg <= 6'h00;
    end else if (clk_if.tick) begin
      ticks_seen_reg <= ticks_seen_reg + 6'h01;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_start_req;
    wr_ctrl && REG_WDATA[asc_pkg::CTRL_START_BIT] && REG_WDATA[asc_pkg::CTRL_EN_BIT] && !busy_reg;
  endsequence
  sequence s_finished;
    !CONV_ACTIVE && done_reg;
  endsequence

  chk_vref_route: assert property (wr_ctrl |=> VREF_PIN_SEL == $past(REG_WDATA[4]))
    else $error("reference pin routing does not follow select bit");
  chk_iref_switch: assert property (wr_setup |=> INT_REF_EN == $past(REG_WDATA[7]))
    else $error("internal reference enable not taken from write");
  chk_left_align: assert property ((rd_res_hi && !align_reg) |=>
    REG_RDATA == $past(result_reg[9:2]))
    else $error("left aligned high byte wrong");
  chk_right_align: assert property ((rd_res_lo && align_reg) |=>
    REG_RDATA == $past(result_reg[7:0]))
    else $error("right aligned low byte wrong");
  chk_align_locked: assert property ((wr_setup && busy_reg) |=> $stable(align_reg))
    else $error("alignment changed during conversion");
  chk_pump_switch: assert property (wr_setup |=> CHARGE_PUMP_EN == $past(REG_WDATA[5]))
    else $error("charge pump enable not taken from write");
  chk_src_decode: assert property (wr_setup |=>
    SRC_VALID == ($past(REG_WDATA[3:0]) <= 4'h9) && INT_REF_SELECTED == ($past(REG_WDATA[3:0]) == 4'h9))
    else $error("input source decode wrong");
  chk_conv_length: assert property (conv_done |-> ticks_seen_reg == 6'(CONV_TICKS - 1))
    else $error("conversion did not end on the last converter clock");
  chk_start_conv: assert property (s_start_req |=> CONV_ACTIVE)
    else $error("start request did not begin a conversion");
  chk_conv_finish: assert property (conv_done |=> s_finished)
    else $error("completion did not clear start and set done");
  chk_enable_bit: assert property (wr_ctrl |=> CONVERTER_EN == $past(REG_WDATA[7]))
    else $error("converter enable not taken from write");
  chk_pin_low: assert property (wr_pin_lo |=> PIN_ANALOG_EN[7:0] == $past(REG_WDATA))
    else $error("low pin configuration not stored");
  chk_pin_high: assert property (wr_pin_hi |=> PIN_ANALOG_EN[8] == $past(REG_WDATA[0]))
    else $error("high pin configuration not stored");
  chk_rsvd_zero: assert property ((rd_setup |=> REG_RDATA[4] == 1'b0) and
    (rd_pin_hi |=> REG_RDATA[7:1] == 7'h00))
    else $error("unimplemented bits read nonzero");

  // done flag: only completion sets it, only a write of 0 clears it
  chk_done_hold: assert property (
    (done_reg && !(wr_ctrl && !REG_WDATA[asc_pkg::CTRL_DONE_BIT])) |=> done_reg)
    else $error("done flag dropped without a clearing write");
  chk_done_clear: assert property (
    (wr_ctrl && !REG_WDATA[asc_pkg::CTRL_DONE_BIT] && !conv_done) |=> !done_reg)
    else $error("done flag not cleared by software write");
  chk_abort_stop: assert property (
    (wr_ctrl && !REG_WDATA[asc_pkg::CTRL_START_BIT]) |=> !CONV_ACTIVE)
    else $error("clearing the start flag did not stop the conversion");
  chk_active_needs_en: assert property (CONV_ACTIVE |-> CONVERTER_EN)
    else $error("conversion running with converter disabled");
  chk_clk_parked: assert property (!CONVERTER_EN |=> !CONV_CLK)
    else $error("converter clock runs while disabled");
  chk_result_latch: assert property (
    conv_done |=> result_reg == $past(CORE_RESULT))
    else $error("result not captured at completion");
  // a free setup write must land in the alignment bit
  chk_align_taken: assert property (
    (wr_setup && !busy_reg) |=> align_reg == $past(REG_WDATA[6]))
    else $error("alignment write refused while idle");
  chk_src_stored: assert property (
    wr_setup |=> INPUT_SOURCE == $past(REG_WDATA[3:0]))
    else $error("input source not taken from write");
  chk_left_low: assert property (
    (rd_res_lo && !align_reg) |=> REG_RDATA == {$past(result_reg[1:0]), 6'h00})
    else $error("left aligned low byte wrong");
  chk_right_high: assert property (
    (rd_res_hi && align_reg) |=> REG_RDATA == {6'h00, $past(result_reg[9:8])})
    else $error("right aligned high byte wrong");
  chk_iref_hold: assert property (
    !wr_setup |=> $stable(INT_REF_EN) && $stable(CHARGE_PUMP_EN))
    else $error("reference or pump enable changed without a write");
  chk_pin_hold: assert property (
    !(wr_pin_lo || wr_pin_hi) |=> $stable(PIN_ANALOG_EN))
    else $error("pin configuration changed without a write");
  chk_vref_hold: assert property (!wr_ctrl |=> $stable(VREF_PIN_SEL))
    else $error("reference pin routing changed without a write");
endmodule

// ---- test/asc_core_model.sv ----
`timescale 1ns/1ps
module asc_core_model (
  input wire logic clk,          // system clock
  input wire logic active,       // conversion in progress
  input wire logic [9:0] sample, // value the next conversion yields
  output logic [9:0] result      // result towards the control block
);
  logic [9:0] junk_reg = 10'h155;
  // outside a conversion the core output is meaningless, so keep it moving
  always @(posedge clk) begin
    junk_reg <= ~junk_reg ^ {junk_reg[8:0], junk_reg[9]};
  end
  assign result = active ? sample : junk_reg;
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  localparam int TICKS = 26;
  localparam int WAIT_MAX = 4000;
  localparam logic [63:0] RST_ADDRS = 64'h8F93_9495_9697_C200;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [9:0] core_result;
  logic [9:0] sample = 10'h000;
  logic conv_clk, conv_active, converter_en, compare_en, vref_pin_sel;
  logic int_ref_en, charge_pump_en, src_valid, int_ref_selected;
  logic [3:0] input_source;
  logic [8:0] pin_analog_en;
  int failures = 0;
  int checks = 0;
  logic [31:0] seed = 32'h0000_0022;
  logic [7:0] d, div, rv;
  int n;
  always #5 ref_clk = ~ref_clk;
  adc_setup_control #(.CONV_TICKS(TICKS)) dut_u (.REF_CLK(ref_clk), .ARST_N(arst_n),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .CORE_RESULT(core_result), .CONV_CLK(conv_clk),
    .CONV_ACTIVE(conv_active), .CONVERTER_EN(converter_en), .COMPARE_EN(compare_en),
    .VREF_PIN_SEL(vref_pin_sel), .INT_REF_EN(int_ref_en), .CHARGE_PUMP_EN(charge_pump_en),
    .INPUT_SOURCE(input_source), .SRC_VALID(src_valid), .INT_REF_SELECTED(int_ref_selected),
    .PIN_ANALOG_EN(pin_analog_en));
  asc_core_model core_u (.clk(ref_clk), .active(conv_active), .sample(sample),
    .result(core_result));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [7:0] exp_hi(input logic [9:0] r, input logic al);
    return al ? {6'h00, r[9:8]} : r[9:2];
  endfunction
  function logic [7:0] exp_lo(input logic [9:0] r, input logic al);
    return al ? r[7:0] : {r[1:0], 6'h00};
  endfunction
  task test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // cycles until the converter clock next rises, or its rising edges until a conversion ends
  task wait_clk(input bit for_done, output int cnt);
    logic prev;
    int j;
    prev = conv_clk;
    cnt = 0;
    for (j = 0; j < WAIT_MAX; j++) begin
      if (for_done && !conv_active) break;
      @(posedge ref_clk);
      #1;
      if (conv_clk && !prev) cnt++;
      if (!for_done && conv_clk && !prev) break;
      prev = conv_clk;
    end
    if (!for_done) cnt = j + 1;
    if (j == WAIT_MAX) begin
      failures++;
      test_done();
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK({src_valid, int_ref_en, pin_analog_en, conv_clk}, 12'h800)
    @(posedge ref_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(RST_ADDRS[8*i +: 8], rv);
      `CHK(rv, 8'h00)
    end
    for (int i = 0; i < 16; i++) begin
      d = 8'(rnd() >> 9) & 8'hF0 | 8'(i);
      wr(8'h8F, d);
      `CHK(int_ref_en, d[7])
      `CHK(charge_pump_en, d[5])
      `CHK({input_source, src_valid, int_ref_selected}, {d[3:0], i <= 9, i == 9})
      rd(8'h8F, rv);
      `CHK(rv, d & 8'hEF)
      d = 8'(rnd() >> 3);
      wr(8'h95, d);
      `CHK(pin_analog_en[7:0], d)
      wr(8'hC2, ~d);
      `CHK(pin_analog_en[8], ~d[0])
      rd(8'hC2, rv);
      `CHK(rv, {7'h00, ~d[0]})
      wr(8'h00, d);
      rd(8'h00, rv);
      `CHK(rv, 8'h00)
    end
    // start without enable is refused, a written 1 does not set done
    wr(8'h93, 8'h7F);
    `CHK({vref_pin_sel, compare_en, converter_en, conv_active}, 4'hC)
    rd(8'h93, rv);
    `CHK(rv, 8'h30)
    wr(8'h93, 8'h80);
    `CHK({converter_en, vref_pin_sel, compare_en}, 3'h4)
    repeat (2000) @(posedge ref_clk);
    for (int k = 0; k < 2; k++) begin
      div = 8'hF0 | 8'(rnd() >> 28);
      wr(8'h94, div);
      wait_clk(1'b0, n);
      wait_clk(1'b0, n);
      `CHK(n, 2 * (256 - div))
      wr(8'h8F, k ? 8'h40 : 8'h00);
      sample = 10'(rnd() >> 7);
      wr(8'h93, 8'h81);
      `CHK(conv_active, 1'b1)
      if (k == 0) begin
        wr(8'h8F, 8'h60);
        rd(8'h8F, rv);
        `CHK(rv, 8'h20)
      end
      wait_clk(1'b1, n);
      if (k == 1) `CHK(n, TICKS)
      rd(8'h93, rv);
      `CHK(rv & 8'hC1, 8'hC0)
      rd(8'h97, rv);
      `CHK(rv, exp_hi(sample, k[0]))
      rd(8'h96, rv);
      `CHK(rv, exp_lo(sample, k[0]))
      wr(8'h93, 8'h80);
      rd(8'h93, rv);
      `CHK(rv & 8'h40, 8'h00)
    end
    // supply monitor on the internal reference at a legal sample rate
    wr(8'h93, 8'h00);
    wr(8'h8F, 8'hA9);
    `CHK({int_ref_en, charge_pump_en, int_ref_selected, src_valid}, 4'hF)
    wr(8'h94, 8'hD9);
    // 100us for the reference; pump settling cut short to keep the run small
    repeat (10000) @(posedge ref_clk);
    wr(8'h93, 8'h80);
    repeat (2000) @(posedge ref_clk);
    wait_clk(1'b0, n);
    wait_clk(1'b0, n);
    `CHK(n, 2 * (256 - 8'hD9))
    sample = 10'(rnd() >> 11);
    wr(8'h93, 8'h81);
    wait_clk(1'b1, n);
    `CHK(n, TICKS)
    rd(8'h97, rv);
    `CHK(rv, exp_hi(sample, 1'b0))
    rd(8'h96, rv);
    `CHK(rv, exp_lo(sample, 1'b0))
    wr(8'h93, 8'h80);
    wr(8'h93, 8'h81);
    wr(8'h93, 8'h80);
    `CHK(conv_active, 1'b0)
    wr(8'h93, 8'h00);
    wr(8'h8F, 8'hBF);
    repeat (8) @(posedge ref_clk);
    #1;
    `CHK({conv_clk, converter_en}, 2'h0)
    arst_n <= 1'b0;
    #1;
    `CHK({src_valid, int_ref_en, charge_pump_en, pin_analog_en}, 12'h800)
    test_done();
  end
endmodule
